// *** inc/acfg_pkg.sv ***
package acfg_pkg;

   // Clock and conversion timing
   localparam int CLK_NS     = 8;
   localparam int CONV_NS    = 290;
   localparam int EARLY_NS   = 100;
   // Longest times round down, never below one cycle
   localparam int CONV_CYC   = (CONV_NS / CLK_NS < 1) ? 1 : CONV_NS / CLK_NS;
   localparam int EARLY_CYC  = (EARLY_NS / CLK_NS < 1) ? 1 : EARLY_NS / CLK_NS;

   // Widths
   localparam int RES_W      = 16;
   localparam int ST_W       = 6;
   localparam int SH_W       = RES_W + ST_W;
   localparam int CFG_W      = 8;
   localparam int CMD_W      = 8;
   localparam int CNT_W      = 6;
   localparam int BIT_W      = 5;

   // Register instruction layout
   localparam logic [BIT_W-1:0] CMD_LAST   = 5'h07;
   localparam logic [BIT_W-1:0] FRAME_LAST = 5'h0F;
   localparam logic [BIT_W-1:0] FRAME_SAT  = 5'h10;
   localparam logic             CMD_PREFIX = 1'h0;
   localparam logic             CMD_READ   = 1'h1;
   localparam logic [5:0]       CMD_FIXED  = 6'h14;
   localparam int               CMD_PFX_B  = 7;
   localparam int               CMD_RW_B   = 6;

   // Configuration register fields
   localparam int BIT_APPEND = 4;
   localparam int BIT_SPAN   = 3;
   localparam int BIT_KICK   = 2;
   localparam int BIT_EARLY  = 1;
   localparam int BIT_OV     = 0;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h01;
   localparam logic [CFG_W-1:0] CFG_WMASK = 8'h1E;

   typedef struct packed {
      logic convert_select;
      logic sck;
      logic sdi;
      logic ov;
   } acfg_pins_t;

   typedef struct packed {
      acfg_pins_t        prev;
      logic              powerup;
      logic              four_wire;
      logic              converting;
      logic [CNT_W-1:0]  cnt;
      logic              acquire;
      logic              pdown;
      logic [SH_W-1:0]   shreg;
      logic              sdi_bit;
      logic              rdy_wait;
      logic [BIT_W-1:0]  bitcnt;
      logic [CMD_W-1:0]  cmd;
      logic              cmd_ok;
      logic              cmd_rd;
      logic              pend_read;
      logic [CFG_W-1:0]  cfg;
      logic              sdo;
      logic              sdo_oe;
   } acfg_state_t;

endpackage : acfg_pkg

// *** logic/acfg_sync.sv ***
`timescale 1ns/10ps
module acfg_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1 <= '0;
         q_o    <= '0;
      end else begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end

endmodule : acfg_sync

// *** logic/acfg_core.sv ***
`timescale 1ns/10ps
module acfg_core #(
   parameter int CONV_CYC  = acfg_pkg::CONV_CYC,
   parameter int EARLY_CYC = acfg_pkg::EARLY_CYC
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       convert_select_i,
   input  wire logic                       sck_i,
   input  wire logic                       sdi_i,
   input  wire logic                       overvoltage_i,
   input  wire logic                       ready_enable_i,
   input  wire logic [acfg_pkg::RES_W-1:0] result_i,
   output logic                            sdo_o,
   output logic                            sdo_oe_o,
   output logic                            acquire_o,
   output logic                            powered_down_o,
   output logic                            span_reduce_o,
   output logic                            low_kickback_o
);

   localparam int SH_W  = acfg_pkg::SH_W;
   localparam int ST_W  = acfg_pkg::ST_W;
   localparam int CFG_W = acfg_pkg::CFG_W;
   localparam logic [acfg_pkg::CNT_W-1:0] CONV_LAST =
      acfg_pkg::CNT_W'(CONV_CYC - 1);
   localparam logic [acfg_pkg::CNT_W-1:0] ACQ_AT =
      acfg_pkg::CNT_W'(CONV_CYC - EARLY_CYC - 1);

   initial begin
      if (CONV_CYC < 2 || CONV_CYC >= (1 << acfg_pkg::CNT_W) ||
          EARLY_CYC < 1 || EARLY_CYC >= CONV_CYC) begin
         $error("acfg_core: conversion timing out of range");
      end
   end

   logic                 rst_meta;
   logic                 rst_n;
   acfg_pkg::acfg_pins_t pin_raw;
   acfg_pkg::acfg_pins_t pin;
   acfg_pkg::acfg_state_t s;
   acfg_pkg::acfg_state_t next_s;

   // Reset released through two flops
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'h0;
         rst_n    <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n    <= rst_meta;
      end
   end

   assign pin_raw = '{convert_select: convert_select_i, sck: sck_i, sdi: sdi_i,
                      ov: overvoltage_i};

   // Synchroniser leaves reset first, so pins are valid once the state runs
   acfg_sync #(
      .W ($bits(acfg_pkg::acfg_pins_t))
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     (pin_raw),
      .q_o     (pin)
   );

   function automatic logic [SH_W-1:0] load_word(
      input logic [acfg_pkg::RES_W-1:0] res,
      input logic [CFG_W-1:0]           cfg
   );
      logic [ST_W-1:0] st;
      st = cfg[acfg_pkg::BIT_APPEND] ? cfg[ST_W-1:0] : '0;
      return {res, st};
   endfunction : load_word

   logic cnv_rise;
   logic cnv_fall;
   logic sck_rise;
   logic sck_fall;
   logic frame;
   logic early;
   logic ready_mode;
   logic [acfg_pkg::CMD_W-1:0] cmd_full;

   always_comb begin
      cnv_rise   = pin.convert_select & ~s.prev.convert_select;
      cnv_fall   = ~pin.convert_select & s.prev.convert_select;
      sck_rise   = pin.sck & ~s.prev.sck;
      sck_fall   = ~pin.sck & s.prev.sck;
      early      = s.cfg[acfg_pkg::BIT_EARLY];
      ready_mode = ready_enable_i & ~early;
      // Four-wire readback is framed by the data input
      frame      = ~pin.convert_select | (s.four_wire & ~pin.sdi);
      cmd_full   = {s.cmd[acfg_pkg::CMD_W-2:0], pin.sdi};
   end

   always_comb begin
      next_s      = s;
      next_s.prev = pin;

      // Conversion phase
      if (cnv_rise && !s.converting) begin
         next_s.converting = 1'h1;
         next_s.cnt        = '0;
         next_s.acquire    = 1'h0;
         next_s.pdown      = 1'h0;
         next_s.powerup    = 1'h0;
         next_s.four_wire  = ~pin.sdi;
         next_s.rdy_wait   = 1'h0;
      end else if (s.converting) begin
         next_s.cnt = s.cnt + 1'h1;
         if (s.cnt == ACQ_AT) begin
            next_s.acquire = 1'h1;
         end
         if (s.cnt == CONV_LAST) begin
            next_s.converting = 1'h0;
            next_s.acquire    = 1'h1;
            next_s.pdown      = 1'h1;
            next_s.shreg      = load_word(result_i, s.cfg);
            next_s.rdy_wait   = ready_mode;
         end
      end

      // Register frame opens on convert_select falling
      if (cnv_fall) begin
         next_s.powerup   = 1'h0;
         next_s.bitcnt    = '0;
         next_s.cmd_ok    = 1'h0;
         next_s.pend_read = 1'h0;
      end

      // Capture on rising edges
      if (sck_rise && frame) begin
         next_s.sdi_bit = pin.sdi;
         if (!pin.convert_select && s.bitcnt != acfg_pkg::FRAME_SAT) begin
            next_s.bitcnt = s.bitcnt + 1'h1;
            next_s.cmd    = cmd_full;
            if (s.bitcnt == acfg_pkg::CMD_LAST) begin
               next_s.cmd_ok =
                  (cmd_full[acfg_pkg::CMD_PFX_B] == acfg_pkg::CMD_PREFIX) &&
                  (cmd_full[5:0] == acfg_pkg::CMD_FIXED);
               next_s.cmd_rd =
                  cmd_full[acfg_pkg::CMD_RW_B] == acfg_pkg::CMD_READ;
               next_s.pend_read = next_s.cmd_ok & next_s.cmd_rd;
            end
            // Whole byte in before any field changes
            if (s.bitcnt == acfg_pkg::FRAME_LAST && s.cmd_ok &&
                !s.cmd_rd) begin
               next_s.cfg = (s.cfg & ~acfg_pkg::CFG_WMASK) |
                            (cmd_full & acfg_pkg::CFG_WMASK);
            end
         end
      end

      // Shift on falling edges
      if (sck_fall && frame) begin
         if (s.pend_read) begin
            next_s.pend_read = 1'h0;
            next_s.shreg[SH_W-1 -: CFG_W] = s.cfg;
            // Clear only once the condition is gone
            if (!pin.ov) begin
               next_s.cfg[acfg_pkg::BIT_OV] = 1'h1;
            end
         end else if (s.rdy_wait) begin
            next_s.rdy_wait = 1'h0;
         end else begin
            next_s.shreg = {s.shreg[SH_W-2:0], s.sdi_bit};
            // Chain data follows the result when no status is sent
            if (!s.cfg[acfg_pkg::BIT_APPEND]) begin
               next_s.shreg[ST_W] = s.sdi_bit;
            end
         end
      end

      // Overvoltage set wins over a read clear
      if (pin.ov) begin
         next_s.cfg[acfg_pkg::BIT_OV] = 1'h0;
      end
      next_s.cfg[CFG_W-1:5] = '0;

      // Data output
      if (next_s.powerup) begin
         next_s.sdo_oe = ~(pin.convert_select & pin.sdi);
         next_s.sdo    = 1'h0;
      end else begin
         next_s.sdo_oe = frame;
         if (s.converting && ready_mode) begin
            next_s.sdo = 1'h1;
         end else if (next_s.rdy_wait) begin
            next_s.sdo = 1'h0;
         end else begin
            next_s.sdo = next_s.shreg[SH_W-1];
         end
      end
   end

   // Reset values load before any frame is seen
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s         <= '0;
         s.powerup <= 1'h1;
         s.pdown   <= 1'h1;
         s.acquire <= 1'h1;
         s.cfg     <= acfg_pkg::CFG_RESET;
         // Idle pin levels, so no false edge follows reset
         s.prev    <= '{convert_select: 1'h1, sck: 1'h0, sdi: 1'h1, ov: 1'h0};
      end else begin
         s <= next_s;
      end
   end

   assign sdo_o          = s.sdo;
   assign sdo_oe_o       = s.sdo_oe;
   assign acquire_o      = s.acquire;
   assign powered_down_o = s.pdown;
   assign span_reduce_o  = s.cfg[acfg_pkg::BIT_SPAN];
   assign low_kickback_o = s.cfg[acfg_pkg::BIT_KICK];

   localparam int CONV_D = CONV_CYC;
   localparam int ACQ_D  = CONV_CYC - EARLY_CYC;

   sequence conv_start_s;
      $rose(s.converting);
   endsequence

   sequence conv_done_s;
      $fell(s.converting) ##0 s.pdown;
   endsequence

   conv_length_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      conv_start_s |-> ##CONV_D conv_done_s)
      else $error("conversion length wrong");

   early_acquire_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      conv_start_s |-> !s.acquire [*2] ##(ACQ_D - 1) s.acquire)
      else $error("acquisition did not restart early");

   power_down_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $fell(s.converting) |-> s.pdown && powered_down_o)
      else $error("no power-down at conversion end");

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      s.cfg[CFG_W-1:5] == '0)
      else $error("reserved bits not zero");

   ov_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $past(pin.ov) |-> !s.cfg[acfg_pkg::BIT_OV])
      else $error("overvoltage flag lost");

   ov_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(s.cfg[acfg_pkg::BIT_OV]) |-> $past(s.pend_read))
      else $error("flag cleared without a read");

   sdo_float_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      !s.powerup && $past(pin.convert_select) && !s.four_wire |-> !sdo_oe_o)
      else $error("data out driven outside frame");

   powerup_sdo_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      s.powerup && $past(rst_n) |->
                    sdo_oe_o == !($past(pin.convert_select) && $past(pin.sdi))
                    && !sdo_o)
      else $error("power-up data out state wrong");

   cfg_write_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      (s.cfg[4:1] != $past(s.cfg[4:1])) |->
         $past(s.bitcnt) == acfg_pkg::FRAME_LAST && $past(s.cmd_ok))
      else $error("field changed before full byte");

   ready_off_a: assert property (@(posedge clk_i) disable iff (!rst_n)
      s.cfg[acfg_pkg::BIT_EARLY] && $fell(s.converting) |-> !s.rdy_wait)
      else $error("ready shown in early readout");

endmodule : acfg_core

// *** tb/acfg_host.sv ***
`timescale 1ns/10ps
module acfg_host (
   input  wire logic sdo_line_i,
   output logic      cnv_o,
   output logic      sck_o,
   output logic      sdi_o
);
   initial begin
      cnv_o = 1'h1;
      sck_o = 1'h0;
      sdi_o = 1'h1;
   end

   // Pins held for power-up combinations
   task automatic park(input logic c, input logic s);
      cnv_o = c;
      sdi_o = s;
   endtask : park

   // Start pulse only, sdi left as it stands
   task automatic pulse();
      cnv_o = 1'h0;
      #62.5 cnv_o = 1'h1;
   endtask : pulse

   // One frame, MSB first; sdi moves only while sck is low
   task automatic xfer(input int n, input logic [23:0] w,
                       output logic [23:0] r);
      r = 24'h000000;
      cnv_o = 1'h0;
      #62.5;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o = w[i];
         #62.5 sck_o = 1'h1;
         r[i] = sdo_line_i;
         #62.5 sck_o = 1'h0;
      end
      #62.5 cnv_o = 1'h1;
      // Idle high so the next start stays three-wire
      sdi_o = 1'h1;
   endtask : xfer
endmodule : acfg_host

// *** tb/tb_adc_serial_config_interface.sv ***
`timescale 1ns/10ps
module tb_adc_serial_config_interface;
   localparam int CONV  = 20;
   localparam int EARLY = 6;
   logic        clk_i   = 1'h0;
   logic        rst_n_i = 1'h0;
   logic        ov_i    = 1'h0;
   logic [15:0] res_i   = 16'h0000;
   logic        sdo_o, sdo_oe_o, acq_o, pdn_o, span_o, kick_o;
   logic        convert_select, sck, sdi;
   logic        rdy_en  = 1'h0;
   logic [7:0]  cfg_m   = 8'h01;
   logic [23:0] r, w;
   int          bad_count = 0;
   int          n_checks  = 0;
   wire         sdo_line = sdo_oe_o ? sdo_o : 1'bz;

   always #4 clk_i = ~clk_i;

   acfg_host host (.sdo_line_i(sdo_line), .cnv_o(convert_select), .sck_o(sck),
                   .sdi_o(sdi));

   acfg_core #(.CONV_CYC(CONV), .EARLY_CYC(EARLY)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .convert_select_i(convert_select),
      .sck_i(sck), .sdi_i(sdi), .overvoltage_i(ov_i),
      .ready_enable_i(rdy_en), .result_i(res_i), .sdo_o(sdo_o),
      .sdo_oe_o(sdo_oe_o), .acquire_o(acq_o), .powered_down_o(pdn_o),
      .span_reduce_o(span_o), .low_kickback_o(kick_o));

   task automatic test_done();
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                        input string m);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, m,
                  seen, exp);
      end
   endtask : check

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask : tick

   // Frame then settle; the closing rise also starts a conversion
   task automatic frame(input int n, input logic [23:0] wd);
      host.xfer(n, wd, r);
      repeat (CONV + 30) tick();
   endtask : frame

   task automatic wr(input logic [7:0] d);
      frame(16, {8'h00, 8'h14, d});
      cfg_m = (d & 8'h1E) | (cfg_m & 8'h01);
   endtask : wr

   task automatic rd(input logic [7:0] exp, input string m);
      frame(16, {8'h00, 8'h54, 8'hFF});
      check(r[7:0], exp, m);
   endtask : rd

   task automatic do_reset(input logic c, input logic s);
      rst_n_i = 1'h0;
      host.park(c, s);
      repeat (2) tick();
      rst_n_i = 1'h1;
      repeat (8) tick();
      check(sdo_oe_o, !(c & s), "power-up enable");
      check(sdo_o, 1'h0, "power-up level");
   endtask : do_reset

   task automatic readout(input logic app);
      logic [15:0] res;
      logic [7:0]  d;
      res = 16'($urandom);
      d = 8'($urandom);
      d[4] = app;
      res_i = res;
      wr(d);
      w = {1'h1, 23'($urandom)};
      host.xfer(24, w, r);
      if (app)
         check(r[23:2], {res, cfg_m[5:0]}, "result and status");
      else begin
         check(r[23:8], res, "result bits");
         check(r[7:0], w[23:16], "chained bits");
      end
      repeat (4) tick();
      check(sdo_oe_o, 1'h0, "sdo released");
      repeat (CONV + 30) tick();
   endtask : readout

   initial begin
      #400us;
      bad_count++;
      test_done();
   end

   initial begin
      logic [7:0]  d;
      int          n;
      logic [15:0] rv;
      w = 24'($urandom(81642));
      for (int i = 0; i < 4; i++)
         do_reset(i[1], i[0]);
      rd(8'h01, "reset value");
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         wr(d);
         rd(cfg_m, "config readback");
         check(span_o, cfg_m[3], "span output");
         check(kick_o, cfg_m[2], "kickback output");
      end
      // Broken prefix and broken fixed pattern must change nothing
      foreach (d[k]) begin
         if (k < 3) begin
            frame(16, {8'h00, (k == 0) ? 8'h94 : (k == 1) ? 8'h15 : 8'h1C,
                       ~cfg_m});
            rd(cfg_m, "bad command");
         end
      end
      host.pulse();
      n = 0;
      while (acq_o !== 1'h0 && n < 20) begin
         tick();
         n++;
      end
      check(pdn_o, 1'h0, "awake in conversion");
      n = 0;
      while (acq_o !== 1'h1 && n < 200) begin
         tick();
         n++;
      end
      check(24'(n), 24'(CONV - EARLY), "early acquire");
      while (pdn_o !== 1'h1 && n < 200) begin
         tick();
         n++;
      end
      check(24'(n), 24'(CONV), "power-down point");
      repeat (10) tick();
      readout(1'h1);
      readout(1'h0);
      // Ready low first, then the result one clock later
      rdy_en = 1'h1;
      rv = 16'($urandom);
      res_i = rv;
      wr(8'h00);
      frame(17, 24'h01FFFF);
      check(r[16:0], {1'h0, rv}, "ready then result");
      rv = 16'($urandom);
      res_i = rv;
      wr(8'h02);
      frame(16, 24'h00FFFF);
      check(r[15:0], rv, "early readout, no ready");
      rdy_en = 1'h0;
      ov_i = 1'h1;
      repeat (10) tick();
      rd(cfg_m & 8'hFE, "flag set");
      ov_i = 1'h0;
      repeat (10) tick();
      rd(cfg_m & 8'hFE, "flag still held");
      rd(cfg_m, "flag cleared");
      test_done();
   end
endmodule : tb_adc_serial_config_interface
